/* File: logic/acnc_pkg.sv */
/*
 Package of the accumulator number conversion unit: operation codes,
 widths and field constants.
 Assumes a single clock domain; no registers reached by software.
*/
`default_nettype none
package acnc_pkg;
	localparam int ACC_W = 32;
	localparam int NIB_W = 4;
	localparam int NUM_DIGITS = 8;
	localparam int SEG_DIGITS = 4;
	localparam int SEG_BYTE_W = 8;
	localparam int REFL_IN_W = 16;
	localparam int BCD_W = 10;
	localparam logic [31:0] ACC_RESET = 32'h0000_0000;
	localparam logic [3:0] ORDER_MIN = 4'h1;
	localparam logic [3:0] ORDER_MAX = 4'h8;
	typedef enum logic [1:0] {
		ACNC_OP_NONE = 2'b00,
		ACNC_OP_SEG = 2'b01,
		ACNC_OP_REFL = 2'b10,
		ACNC_OP_REORDER = 2'b11
	} acnc_op_t;
endpackage
`default_nettype wire

/* File: logic/acnc_unit.sv */
/*
 Accumulator number conversion unit: seven-segment convert, reflected
 code to decimal, and digit reorder, with zero and negative flags.
 Assumes the sequencer presents the accumulator and first stack level
 on the same clock and pulses op_valid for one cycle per operation.
*/
// Functional notes
// - Segment convert turns four accumulator hex digits into segment patterns.
// - Reflected code convert turns 16-bit code into BCD in low 10 bits.
// - After reflected code convert, upper 22 accumulator bits are zero.
// - Conversion is exact for encoders of up to 400 counts (values 0 to 399).
// - Zero flag follows result after reflected convert or reorder.
// - Negative flag follows result MSB after reflected convert or reorder.
// - Reorder rearranges up to eight stack digits into the accumulator.
// - Order nibble at position p names destination of stack digit p.
// - Order nibble 0 or 9 to F drops that source digit.
// - Duplicate destinations take digit of most significant order nibble.
`timescale 1ns/1ps
`default_nettype none
module acnc_unit (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic op_valid,
	input wire acnc_pkg::acnc_op_t op_code,
	input wire logic [31:0] acc_in,
	input wire logic [31:0] stack1_in,
	output logic [31:0] acc_out,
	output logic result_zero_flag,
	output logic result_negative_flag,
	output logic done
);

	////////////////////////////////////////////////////////////////////
	// Segment pattern of one hex digit, a in bit 0 .. g in bit 6
	function automatic logic [7:0] acnc_seg(input logic [3:0] d);
		logic [7:0] s;
		s = 8'h00;
		unique case (d)
			4'h0: s = 8'h3F;
			4'h1: s = 8'h06;
			4'h2: s = 8'h5B;
			4'h3: s = 8'h4F;
			4'h4: s = 8'h66;
			4'h5: s = 8'h6D;
			4'h6: s = 8'h7D;
			4'h7: s = 8'h07;
			4'h8: s = 8'h7F;
			4'h9: s = 8'h6F;
			4'hA: s = 8'h77;
			4'hB: s = 8'h7C;
			4'hC: s = 8'h39;
			4'hD: s = 8'h5E;
			4'hE: s = 8'h79;
			4'hF: s = 8'h71;
		endcase
		return s;
	endfunction

	// Order nibble is a usable destination 1..8
	function automatic logic acnc_ord_ok(input logic [3:0] o);
		return (o >= acnc_pkg::ORDER_MIN) && (o <= acnc_pkg::ORDER_MAX);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Seven-segment result, digit 0 in the low byte
	wire logic [31:0] seg_res;
	genvar gi;
	generate
		for (gi = 0; gi < acnc_pkg::SEG_DIGITS; gi++) begin : g_seg
			assign seg_res[gi*8 +: 8] = acnc_seg(acc_in[gi*4 +: 4]);
		end
	endgenerate

	// Reflected code to binary: each bit is xor of its own code bit and all code bits above
	wire logic [15:0] refl_bin;
	assign refl_bin[15] = acc_in[15];
	generate
		for (gi = 0; gi < 15; gi++) begin : g_refl
			assign refl_bin[gi] = refl_bin[gi+1] ^ acc_in[gi];
		end
	endgenerate

	// Binary to BCD by shift-and-add-three, low ten bits kept
	logic [31:0] refl_res;
	always_comb begin
		logic [19:0] bcd;
		bcd = 20'h00000;
		for (int i = 15; i >= 0; i--) begin
			for (int k = 0; k < 5; k++) begin
				if (bcd[k*4 +: 4] >= 4'h5) begin
					bcd[k*4 +: 4] = bcd[k*4 +: 4] + 4'h3;
				end
			end
			bcd = {bcd[18:0], refl_bin[i]};
		end
		refl_res = {22'h000000, bcd[9:0]};
	end

	// Digit reorder: higher source positions overwrite lower ones
	logic [31:0] reord_res;
	always_comb begin
		logic [3:0] dst;
		reord_res = 32'h0000_0000;
		dst = 4'h0;
		for (int p = 0; p < acnc_pkg::NUM_DIGITS; p++) begin
			dst = acc_in[p*4 +: 4];
			if (acnc_ord_ok(dst)) begin
				reord_res[(dst - 4'h1)*4 +: 4] = stack1_in[p*4 +: 4];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Result selection
	wire logic [31:0] op_res;
	wire logic op_flags;
	assign op_res = (op_code == acnc_pkg::ACNC_OP_SEG) ? seg_res :
		(op_code == acnc_pkg::ACNC_OP_REFL) ? refl_res :
		(op_code == acnc_pkg::ACNC_OP_REORDER) ? reord_res : acc_in;
	assign op_flags = (op_code == acnc_pkg::ACNC_OP_REFL) ||
		(op_code == acnc_pkg::ACNC_OP_REORDER);

	logic [31:0] acc_reg;
	logic zero_reg;
	logic neg_reg;
	logic done_reg;

	// Accumulator updated on an accepted operation, flags only on reflected convert or reorder
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_reg <= acnc_pkg::ACC_RESET;
			zero_reg <= 1'b0;
			neg_reg <= 1'b0;
			done_reg <= 1'b0;
		end else if (clk_en) begin
			done_reg <= op_valid && (op_code != acnc_pkg::ACNC_OP_NONE);
			if (op_valid && (op_code != acnc_pkg::ACNC_OP_NONE)) begin
				acc_reg <= op_res;
			end
			if (op_valid && op_flags) begin
				zero_reg <= (op_res == 32'h0000_0000);
				neg_reg <= op_res[31];
			end
		end
	end

	assign acc_out = acc_reg;
	assign result_zero_flag = zero_reg;
	assign result_negative_flag = neg_reg;
	assign done = done_reg;

	////////////////////////////////////////////////////////////////////
	// Checks
	wire logic take;
	assign take = clk_en && op_valid;

	property p_refl_upper;
		@(posedge clk) disable iff (!rst_n)
		(take && op_code == acnc_pkg::ACNC_OP_REFL) |=>
			(acc_out[31:10] == 22'h000000) && !result_negative_flag;
	endproperty
	refl_upper_a: assert property (p_refl_upper)
		else $error("upper bits not cleared");

	refl_value_a: assert property (@(posedge clk) disable iff (!rst_n)
		(take && op_code == acnc_pkg::ACNC_OP_REFL && acc_in[15:0] == 16'h0000)
		|=> acc_out == 32'h0000_0000 && result_zero_flag)
		else $error("zero code not converted to zero");

	seg_digit_a: assert property (@(posedge clk) disable iff (!rst_n)
		(take && op_code == acnc_pkg::ACNC_OP_SEG && acc_in[15:0] == 16'h0008)
		|=> acc_out == 32'h3F3F_3F7F)
		else $error("segment pattern wrong");

	seg_bit7_a: assert property (@(posedge clk) disable iff (!rst_n)
		(take && op_code == acnc_pkg::ACNC_OP_SEG) |=>
			(acc_out & 32'h8080_8080) == 32'h0000_0000)
		else $error("segment bit 7 set");

	zero_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		(take && op_flags) |=>
			result_zero_flag == (acc_out == 32'h0000_0000))
		else $error("zero flag mismatch");

	neg_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		(take && op_flags) |=> result_negative_flag == acc_out[31])
		else $error("negative flag mismatch");

	reord_ident_a: assert property (@(posedge clk) disable iff (!rst_n)
		(take && op_code == acnc_pkg::ACNC_OP_REORDER &&
			acc_in == 32'h8765_4321) |=> acc_out == $past(stack1_in))
		else $error("identity reorder wrong");

	reord_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
		(take && op_code == acnc_pkg::ACNC_OP_REORDER &&
			acc_in == 32'h0009_FFA0) |=> acc_out == 32'h0000_0000)
		else $error("invalid order not dropped");

	reord_dup_a: assert property (@(posedge clk) disable iff (!rst_n)
		(take && op_code == acnc_pkg::ACNC_OP_REORDER &&
			acc_in == 32'h0000_0011) |=>
			acc_out == {28'h0000000, $past(stack1_in[7:4])})
		else $error("duplicate order not resolved");

	hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!take |=> $stable(acc_out) && !done)
		else $error("accumulator changed without operation");

	cov_seg_c: cover property (@(posedge clk) disable iff (!rst_n)
		take && op_code == acnc_pkg::ACNC_OP_SEG);
	cov_refl_c: cover property (@(posedge clk) disable iff (!rst_n)
		take && op_code == acnc_pkg::ACNC_OP_REFL ##1 result_zero_flag);
	cov_reord_c: cover property (@(posedge clk) disable iff (!rst_n)
		take && op_code == acnc_pkg::ACNC_OP_REORDER ##1
			result_negative_flag);
endmodule
`default_nettype wire

/* File: sim/acnc_seq.sv */
/*
 Sequencer model: preloads the first stack level, then loads the accumulator
 and pulses one operation request on that same clock.
 Assumes the bench holds code, opa and stk steady between go pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module acnc_seq (
	input wire logic clk,
	input wire logic go,
	input wire logic [1:0] code,
	input wire logic [31:0] opa,
	input wire logic [31:0] stk,
	output logic op_valid,
	output acnc_pkg::acnc_op_t op_code,
	output logic [31:0] acc_in,
	output logic [31:0] stack1_in
);
	logic load_reg;
	// Known levels at time zero
	initial begin
		{load_reg, op_valid, acc_in, stack1_in} = '0;
		op_code = acnc_pkg::ACNC_OP_NONE;
	end
	// Stack first, accumulator next; idle lines toggle, never hold
	// Raw converted value is passed on; no encoder offset applied
	always @(posedge clk) begin
		load_reg <= go;
		op_valid <= load_reg;
		stack1_in <= (go || load_reg) ? stk : ~stack1_in;
		acc_in <= load_reg ? opa : ~acc_in;
		op_code <= acnc_pkg::acnc_op_t'(load_reg ? code : ~op_code);
	end
endmodule
`default_nettype wire

/* File: sim/acnc_unit_bench.sv */
/*
 Self-checking bench of the conversion unit: driver notes expectations,
 a monitor compares them whenever done pulses.
 Assumes the sequencer model drives the operand ports.
*/
`timescale 1ns/1ps
`default_nettype none
module acnc_unit_bench;
	localparam logic [127:0] SEGT = 128'h71795E397C776F7F077D6D664F5B063F;
	logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, go = 1'b0;
	logic [1:0] code = 2'h0, flags = 2'h0;
	logic [31:0] opa = '0, stk = '0, acc_out, acc_in, stack1_in;
	logic op_valid, result_zero_flag, result_negative_flag, done;
	acnc_pkg::acnc_op_t op_code;
	logic [33:0] q[$];
	int n_mismatch = 0, compares = 0, cycles = 0;
	acnc_seq u_acnc_seq (.clk(clk), .go(go), .code(code), .opa(opa),
		.stk(stk), .op_valid(op_valid), .op_code(op_code), .acc_in(acc_in),
		.stack1_in(stack1_in));
	acnc_unit u_acnc_unit (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
		.op_valid(op_valid), .op_code(op_code), .acc_in(acc_in),
		.stack1_in(stack1_in), .acc_out(acc_out),
		.result_zero_flag(result_zero_flag),
		.result_negative_flag(result_negative_flag), .done(done));
	////////////////////////////////////////////////////////////////////////
	// Expected accumulator for one operation
	function automatic logic [31:0] ref_acc(logic [1:0] c, logic [31:0] a,
		logic [31:0] s);
		logic [15:0] b;
		logic [31:0] r;
		int n;
		r = '0;
		b = '0;
		case (c)
			2'h1: for (int i = 0; i < 4; i++) r[8*i+:8] = SEGT[8*a[4*i+:4]+:8];
			2'h2: begin
				b[15] = a[15];
				for (int i = 14; i >= 0; i--) b[i] = b[i+1] ^ a[i];
				r[9:0] = 10'(b % 10 + (b / 10 % 10) * 16 + (b / 100 % 10) * 256);
			end
			2'h3: for (int p = 0; p < 8; p++) begin
				n = a[4*p+:4];
				if (n >= 1 && n <= 8) r[4*(n-1)+:4] = s[4*p+:4];
			end
			default: ;
		endcase
		return r;
	endfunction
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		if (n_mismatch == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Issue one operation; en low means the request is frozen out
	task automatic op(input logic [1:0] c, input logic [31:0] a,
		input logic [31:0] s, input logic en);
		logic [31:0] r;
		r = ref_acc(c, a, s);
		if (c != 2'h0 && en) begin
			if (c != 2'h1) flags = {r[31], r == 32'h0};
			q.push_back({flags, r});
		end
		code <= c;
		opa <= a;
		stk <= s;
		go <= 1'b1;
		clk_en <= en;
		@(posedge clk);
		go <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Clock and cycle limit
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_mismatch++;
			complete_run();
		end
	end
	// Monitor: each done pulse consumes the oldest note
	always @(negedge clk) begin
		if (done === 1'b1) begin
			if (q.size() == 0) check(34'h1, 34'h0);
			else check({result_negative_flag, result_zero_flag, acc_out},
				q.pop_front());
		end
	end
	// Main sequence
	initial begin
		void'($urandom(8396));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		op(2'h3, 32'h12873654, 32'h9ABCDEF0, 1'b1);
		op(2'h3, 32'h0F9A5511, 32'h87654321, 1'b1);
		op(2'h2, 32'hFFFF0000, 32'h0, 1'b1);
		op(2'h3, 32'h80000000, 32'h90000000, 1'b1);
		op(2'h1, 32'h89ABCDEF, 32'h0, 1'b1);
		op(2'h1, 32'h00000008, 32'h0, 1'b1);
		op(2'h3, 32'h87654321, $urandom, 1'b1);
		op(2'h3, 32'h0009FFA0, 32'h12345678, 1'b1);
		op(2'h3, 32'h00000011, 32'h000000A5, 1'b1);
		op(2'h0, 32'h1234, 32'h0, 1'b1);
		op(2'h2, 32'h1234, 32'h0, 1'b0);
		for (int i = 0; i < 40; i++)
			op(2'(1 + $urandom % 3), $urandom, $urandom, 1'b1);
		check(34'(q.size()), 34'h0);
		complete_run();
	end
endmodule
`default_nettype wire
